//--- verilog/wave_seq_map.svh
// Constants of the waveform point sequencer: sizes, limits, timing, register map.
// Assumes a 125 MHz system clock and word addresses on the register port.
`ifndef WAVE_SEQ_MAP_SVH
`define WAVE_SEQ_MAP_SVH

// ----------------------------------------------------------------
// Sizes and point budget
// ----------------------------------------------------------------
`define WSQ_SLOTS 16
`define WSQ_SETUPS 16
`define WSQ_MAX_SEGS 10
`define WSQ_MAX_POINTS 3933
`define WSQ_LEVEL_POINTS 60
`define WSQ_FULL_TURN 360

// ----------------------------------------------------------------
// Frequency limits in mHz
// ----------------------------------------------------------------
`define WSQ_FMIN_SINE_MHZ 1
`define WSQ_FMIN_RAMP_MHZ 10
`define WSQ_FMIN_SQUARE_MHZ 20
`define WSQ_FMIN_LEVEL_MHZ 1
`define WSQ_FMAX_SINE_MHZ 443000
`define WSQ_FMAX_RAMP_MHZ 532000
`define WSQ_FMAX_SQUARE_MHZ 1000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WSQ_CLK_HZ 125000000
`define WSQ_MHZ_PER_HZ 1000
`define WSQ_OVR_HOLD_MS 500
`define WSQ_OVR_HOLD_CYCLES (`WSQ_OVR_HOLD_MS * (`WSQ_CLK_HZ / 1000))

// ----------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------
`define OFF_COMMAND 8'h00
`define OFF_SELECT 8'h01
`define OFF_WAVE_HDR 8'h02
`define OFF_WAVE_PROT 8'h03
`define OFF_WAVE_NAME 8'h04
`define OFF_SEG_FREQ 8'h05
`define OFF_SEG_SHAPE 8'h06
`define OFF_SEG_LEVEL 8'h07
`define OFF_STATIC_SET 8'h08
`define OFF_STATIC_PROT 8'h09
`define OFF_STATUS 8'h0a
`define OFF_ERRORS 8'h0b
`define OFF_SETPOINT 8'h0c

// ----------------------------------------------------------------
// Command and error bit positions
// ----------------------------------------------------------------
`define CMD_RUN 0
`define CMD_STOP 1
`define CMD_ADD_SEG 2
`define CMD_ERASE 3
`define CMD_SAVE_SETUP 4
`define CMD_RECALL_SETUP 5
`define ERR_OVERRUN 0
`define ERR_COUNT 1
`define ERR_FREQ 2
`define ERR_EMPTY 3

`endif

//--- verilog/wave_seq_pkg.sv
// Types of the waveform point sequencer.
// Assumes wave_seq_map.svh supplies the numbers.
package wave_seq_pkg;

  typedef enum logic [2:0] {
    KIND_LEVEL = 3'h0,
    KIND_SQUARE = 3'h1,
    KIND_SINE = 3'h2,
    KIND_TRIANGLE = 3'h3,
    KIND_RAMP_UP = 3'h4,
    KIND_RAMP_DOWN = 3'h5
  } seg_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_PLAY = 2'h3
  } play_state_t;

  typedef struct packed {
    seg_kind_t kind;
    logic initialOnly;
    logic [19:0] freq;
    logic [15:0] amp;
    logic signed [15:0] offset;
    logic [8:0] startAng;
    logic [8:0] stopAng;
    logic [4:0] code;
    logic [11:0] charged;
  } seg_t;

  typedef struct packed {
    logic currentMode;
    logic signed [15:0] level;
    logic [15:0] protPos;
    logic [15:0] protNeg;
  } setpoint_t;

endpackage

//--- verilog/wave_seq.sv
// Waveform point sequencer: slot store, point budget, playback to the output stage.
// Assumes one register master on clk_sys and an output stage that takes setpoints.
//
// Contract
// R1: Sixteen stored waveform slots for later playback
// R2: Slot holds name, mode, cycles, protection pair
// R3: Zero cycle count repeats forever
// R4: One to ten segments; refuse others
// R5: Segment holds type, frequency, amplitude, offset, angles, flag
// R6: Output steps through discrete shaped setpoints
// R7: Waveform point total never exceeds 3933
// R8: Level segment costs at most 60 points
// R9: Budget check per add; refuse, flag overrun
// R10: Partial angle span charges proportionally fewer points
// R11: Sine/triangle/ramp points from frequency table
// R12: Square points from separate frequency table
// R13: Fixed points per range; dwell scales with period
// R14: Reject sine or triangle above 443 Hz
// R15: Reject ramp above 532 Hz
// R16: Sine and triangle go down to 0.001 Hz
// R17: Static setpoints drive output until playback starts
// R18: Erased slot reads back as empty
// R19: Recall loads stored setup onto output
// R20: Initial segments play on first pass only
// R21: Last segment always repeats
// R22: Dwell ticks derived from period over points
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "wave_seq_map.svh"

module wave_seq #(
  parameter int unsigned OVR_HOLD = `WSQ_OVR_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdata,
  output wave_seq_pkg::setpoint_t outSet,
  output logic running,
  output logic overrunInd
);

  // ----------------------------------------------------------------
  // Reset release and tables
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  wire rstN = rstSync[1];
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) rstSync <= 2'h0;
    else if (ce) rstSync <= {rstSync[0], 1'b1};

  localparam logic [39:0] TICK_WRAP = 40'(`WSQ_CLK_HZ) * 40'(`WSQ_MHZ_PER_HZ);
  localparam logic [21:0][11:0] POINTS = {12'd10, 12'd12, 12'd20, 12'd24, 12'd30, 12'd36,
    12'd48, 12'd60, 12'd72, 12'd90, 12'd120, 12'd160, 12'd192, 12'd240, 12'd320, 12'd480,
    12'd720, 12'd960, 12'd1280, 12'd1920, 12'd2880, 12'd3840};
  // Upper bounds of each range in mHz; entries 20 and 21 unused for sine
  localparam logic [21:0][19:0] SINE_TOP = {20'd0, 20'd0, 20'd532000, 20'd443700, 20'd354900,
    20'd295800, 20'd221800, 20'd177400, 20'd147900, 20'd118300, 20'd88700, 20'd66500,
    20'd55400, 20'd44300, 20'd33200, 20'd22100, 20'd14700, 20'd11000, 20'd8300, 20'd5500,
    20'd3600, 20'd2700};
  localparam logic [21:0][19:0] SQUARE_TOP = {20'd1000000, 20'd652500, 20'd435000,
    20'd261000, 20'd217500, 20'd174000, 20'd145000, 20'd108700, 20'd87000, 20'd72500,
    20'd58000, 20'd43500, 20'd32600, 20'd27100, 20'd21700, 20'd16300, 20'd10800, 20'd7200,
    20'd5400, 20'd4000, 20'd2700, 20'd1800};

  // Phase step per point, 2^32 / points; built at elaboration to avoid a divider
  function automatic logic [21:0][31:0] makeSteps();
    logic [21:0][31:0] s;
    for (int i = 0; i < 22; i++)
      s[i] = 32'(33'h100000000 / 33'(POINTS[i]));
    return s;
  endfunction
  localparam logic [21:0][31:0] STEPS = makeSteps();

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  wave_seq_pkg::seg_t segMem [`WSQ_SLOTS][`WSQ_MAX_SEGS]; // [R1] [R5]
  logic hdrMode [`WSQ_SLOTS]; // [R2]
  logic [15:0] hdrCycles [`WSQ_SLOTS];
  logic [15:0] hdrPos [`WSQ_SLOTS];
  logic [15:0] hdrNeg [`WSQ_SLOTS];
  logic [31:0] hdrName [`WSQ_SLOTS];
  logic [3:0] segCount [`WSQ_SLOTS];
  logic [12:0] pointsUsed [`WSQ_SLOTS];
  wave_seq_pkg::setpoint_t setupMem [`WSQ_SETUPS];
  wave_seq_pkg::setpoint_t staticSet;
  logic [3:0] slotSel;
  logic [3:0] setupSel;
  logic [19:0] stFreq;
  logic [21:0] stShape;
  logic [31:0] stLevel;
  logic [3:0] errors;
  logic [31:0] ovrTimer;
  logic [3:0] runSlot;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wrCmd = wrEn && addr == `OFF_COMMAND;
  wire cmdRun = wrCmd && wdata[`CMD_RUN];
  wire cmdStop = wrCmd && wdata[`CMD_STOP];
  wire cmdAdd = wrCmd && wdata[`CMD_ADD_SEG];
  wire cmdErase = wrCmd && wdata[`CMD_ERASE];
  wire cmdSave = wrCmd && wdata[`CMD_SAVE_SETUP];
  wire cmdRecall = wrCmd && wdata[`CMD_RECALL_SETUP];
  // Edits to the slot being played are refused so playback never reads a half-built slot
  wire slotBusy = running && slotSel == runSlot;

  // ----------------------------------------------------------------
  // Segment validation on add
  // ----------------------------------------------------------------
  wire wave_seq_pkg::seg_kind_t stKind = wave_seq_pkg::seg_kind_t'(stShape[2:0]);
  wire [8:0] stStart = stShape[12:4];
  wire [8:0] stStop = stShape[21:13];
  wire isSquare = stKind == wave_seq_pkg::KIND_SQUARE;
  wire isLevel = stKind == wave_seq_pkg::KIND_LEVEL;
  logic [19:0] fMin;
  logic [19:0] fMax;
  logic kindOk;
  logic [4:0] stCode;

  always_comb
  begin
    kindOk = 1'b1;
    fMin = 20'(`WSQ_FMIN_LEVEL_MHZ);
    fMax = 20'(`WSQ_FMAX_SQUARE_MHZ);
    case (stKind)
      wave_seq_pkg::KIND_LEVEL: ;
      wave_seq_pkg::KIND_SQUARE: fMin = 20'(`WSQ_FMIN_SQUARE_MHZ);
      wave_seq_pkg::KIND_SINE, wave_seq_pkg::KIND_TRIANGLE:
      begin
        fMin = 20'(`WSQ_FMIN_SINE_MHZ); // [R16]
        fMax = 20'(`WSQ_FMAX_SINE_MHZ); // [R14]
      end
      wave_seq_pkg::KIND_RAMP_UP, wave_seq_pkg::KIND_RAMP_DOWN:
      begin
        fMin = 20'(`WSQ_FMIN_RAMP_MHZ);
        fMax = 20'(`WSQ_FMAX_RAMP_MHZ); // [R15]
      end
      default: kindOk = 1'b0;
    endcase
  end

  // First range whose top bound covers the frequency
  always_comb
  begin
    stCode = 5'd21;
    for (int i = 21; i >= 0; i--)
      if (stFreq <= (isSquare ? SQUARE_TOP[i] : SINE_TOP[i])) // [R11] [R12]
        stCode = 5'(i);
  end

  wire freqOk = kindOk && stFreq >= fMin && stFreq <= fMax;
  wire [11:0] stPts = isLevel ? 12'(`WSQ_LEVEL_POINTS) : POINTS[stCode]; // [R8]
  wire [8:0] stSpan = (stStop > stStart) ? stStop - stStart : 9'(`WSQ_FULL_TURN);
  wire [20:0] scaled = (21'(stPts) * 21'(stSpan)) / 21'(`WSQ_FULL_TURN); // [R10]
  wire [11:0] stCharged = (scaled == 21'h0) ? 12'h1 : scaled[11:0];
  wire [12:0] newTotal = pointsUsed[slotSel] + 13'(stCharged);
  wire overBudget = newTotal > 13'(`WSQ_MAX_POINTS); // [R7] [R9]
  wire countFull = segCount[slotSel] == 4'(`WSQ_MAX_SEGS); // [R4]
  wire addOk = cmdAdd && !slotBusy && freqOk && !overBudget && !countFull;
  wire wave_seq_pkg::seg_t newSeg = '{kind: stKind, initialOnly: stShape[3], freq: stFreq,
    amp: stLevel[15:0], offset: stLevel[31:16], startAng: stStart, stopAng: stStop,
    code: stCode, charged: stCharged};

  always_ff @(posedge clk_sys)
    if (ce && addOk)
      segMem[slotSel][segCount[slotSel]] <= newSeg;

  // ----------------------------------------------------------------
  // Slot headers and setups
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      for (int i = 0; i < `WSQ_SLOTS; i++)
      begin
        hdrMode[i] <= 1'b0;
        hdrCycles[i] <= 16'h0;
        hdrPos[i] <= 16'h0;
        hdrNeg[i] <= 16'h0;
        hdrName[i] <= 32'h0;
        segCount[i] <= 4'h0;
        pointsUsed[i] <= 13'h0;
      end
    end
    else if (ce && !slotBusy)
    begin
      if (wrEn && addr == `OFF_WAVE_HDR)
      begin
        hdrCycles[slotSel] <= wdata[15:0];
        hdrMode[slotSel] <= wdata[16];
      end
      if (wrEn && addr == `OFF_WAVE_PROT)
      begin
        hdrPos[slotSel] <= wdata[15:0];
        hdrNeg[slotSel] <= wdata[31:16];
      end
      if (wrEn && addr == `OFF_WAVE_NAME)
        hdrName[slotSel] <= wdata;
      if (addOk)
      begin
        segCount[slotSel] <= segCount[slotSel] + 4'h1;
        pointsUsed[slotSel] <= newTotal;
      end
      if (cmdErase)
      begin
        segCount[slotSel] <= 4'h0; // [R18]
        pointsUsed[slotSel] <= 13'h0;
        hdrName[slotSel] <= 32'h0;
      end
    end

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      for (int i = 0; i < `WSQ_SETUPS; i++)
        setupMem[i] <= '0;
    end
    else if (ce && cmdSave)
      setupMem[setupSel] <= staticSet;

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      staticSet <= '0;
      slotSel <= 4'h0;
      setupSel <= 4'h0;
      stFreq <= 20'h0;
      stShape <= 22'h0;
      stLevel <= 32'h0;
    end
    else if (ce)
    begin
      if (cmdRecall)
        staticSet <= setupMem[setupSel]; // [R19]
      if (wrEn && addr == `OFF_STATIC_SET)
        {staticSet.currentMode, staticSet.level} <= wdata[16:0];
      if (wrEn && addr == `OFF_STATIC_PROT)
        {staticSet.protNeg, staticSet.protPos} <= wdata;
      if (wrEn && addr == `OFF_SELECT)
        {setupSel, slotSel} <= wdata[7:0];
      if (wrEn && addr == `OFF_SEG_FREQ)
        stFreq <= wdata[19:0];
      if (wrEn && addr == `OFF_SEG_SHAPE)
        stShape <= wdata[21:0];
      if (wrEn && addr == `OFF_SEG_LEVEL)
        stLevel <= wdata;
    end

  // ----------------------------------------------------------------
  // Playback sequencer
  // ----------------------------------------------------------------
  wave_seq_pkg::play_state_t state;
  wave_seq_pkg::seg_t cur;
  logic [3:0] segIdx;
  logic [15:0] passCnt;
  logic [11:0] remaining;
  logic [31:0] phase;
  logic [39:0] acc;

  wave_seq_pkg::seg_t fetched;
  assign fetched = segMem[runSlot][segIdx];
  wire [3:0] lastIdx = segCount[runSlot] - 4'h1;
  wire isLast = segIdx == lastIdx;
  wire skipSeg = passCnt != 16'h0 && fetched.initialOnly && !isLast; // [R20] [R21]
  wire [16:0] passNext = 17'(passCnt) + 17'h1;
  wire allDone = hdrCycles[runSlot] != 16'h0 && passNext == 17'(hdrCycles[runSlot]); // [R3]
  wire [11:0] curPts = (cur.kind == wave_seq_pkg::KIND_LEVEL) ?
    12'(`WSQ_LEVEL_POINTS) : POINTS[cur.code];
  // Tick rate is freq * points, so dwell = period / points without a divider
  wire [39:0] accSum = acc + 40'(cur.freq) * 40'(curPts); // [R13] [R22]
  wire tick = accSum >= TICK_WRAP; // [R22]
  wire segEnd = tick && remaining == 12'h1;
  wire startOk = cmdRun && segCount[slotSel] != 4'h0; // [R4]
  wire [31:0] startPhase = 32'(fetched.startAng) * 32'd11930465;

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      state <= wave_seq_pkg::ST_IDLE;
      cur <= '0;
      runSlot <= 4'h0;
      segIdx <= 4'h0;
      passCnt <= 16'h0;
      remaining <= 12'h0;
      phase <= 32'h0;
      acc <= 40'h0;
    end
    else if (ce)
    begin
      case (state)
        wave_seq_pkg::ST_IDLE:
          if (startOk)
          begin
            runSlot <= slotSel;
            segIdx <= 4'h0;
            passCnt <= 16'h0;
            state <= wave_seq_pkg::ST_LOAD;
          end
        wave_seq_pkg::ST_LOAD:
          if (skipSeg)
            segIdx <= segIdx + 4'h1;
          else
          begin
            cur <= fetched;
            remaining <= fetched.charged;
            phase <= startPhase;
            acc <= 40'h0;
            state <= wave_seq_pkg::ST_PLAY;
          end
        wave_seq_pkg::ST_PLAY:
        begin
          acc <= tick ? accSum - TICK_WRAP : accSum;
          if (tick)
          begin
            remaining <= remaining - 12'h1;
            phase <= phase + STEPS[cur.code]; // [R6]
          end
          if (segEnd && !isLast)
          begin
            segIdx <= segIdx + 4'h1;
            state <= wave_seq_pkg::ST_LOAD;
          end
          else if (segEnd && allDone)
            state <= wave_seq_pkg::ST_IDLE;
          else if (segEnd)
          begin
            segIdx <= 4'h0;
            passCnt <= passNext[15:0];
            state <= wave_seq_pkg::ST_LOAD;
          end
        end
        default: state <= wave_seq_pkg::ST_IDLE;
      endcase
      if (cmdStop)
        state <= wave_seq_pkg::ST_IDLE;
    end

  // ----------------------------------------------------------------
  // Shape generation, normalised to +-65536
  // ----------------------------------------------------------------
  wire [15:0] ph = phase[31:16];
  wire signed [19:0] rampW = $signed({3'b000, ph, 1'b0}) - 20'sd65536;
  wire signed [19:0] quad = $signed({2'b00, ph, 2'b00});
  wire [29:0] hump = 30'(ph[14:0]) * 30'(16'h8000 - {1'b0, ph[14:0]});
  wire signed [19:0] humpW = $signed({2'b00, hump[29:12]});
  logic signed [19:0] shapeW;

  always_comb
  begin
    case (cur.kind)
      wave_seq_pkg::KIND_SQUARE: shapeW = ph[15] ? -20'sd65536 : 20'sd65536;
      wave_seq_pkg::KIND_SINE: shapeW = ph[15] ? -humpW : humpW;
      wave_seq_pkg::KIND_TRIANGLE:
        if (ph < 16'h4000)
          shapeW = quad;
        else if (ph < 16'hc000)
          shapeW = 20'sd131072 - quad;
        else
          shapeW = quad - 20'sd262144;
      wave_seq_pkg::KIND_RAMP_UP: shapeW = rampW;
      wave_seq_pkg::KIND_RAMP_DOWN: shapeW = -rampW;
      default: shapeW = 20'sd0;
    endcase
  end

  wire signed [37:0] scaledW = $signed({1'b0, cur.amp}) * shapeW;
  wire signed [17:0] rawLevel = 18'(scaledW >>> 17) + 18'(cur.offset);
  wire signed [15:0] genLevel = (rawLevel > 18'sd32767) ? 16'sh7fff :
    (rawLevel < -18'sd32768) ? 16'sh8000 : rawLevel[15:0];

  // ----------------------------------------------------------------
  // Outputs, errors and read-back
  // ----------------------------------------------------------------
  wire [3:0] errSet = {cmdRun && !startOk, cmdAdd && !slotBusy && !freqOk,
    cmdAdd && !slotBusy && countFull, cmdAdd && !slotBusy && freqOk && !countFull && overBudget};
  wire [31:0] statusWord = {4'h0, 3'h0, pointsUsed[slotSel], segIdx, segCount[slotSel],
    1'b0, segCount[slotSel] == 4'h0, overrunInd, running};
  logic [31:0] readMux;

  always_comb
  begin
    case (addr)
      `OFF_SELECT: readMux = {24'h0, setupSel, slotSel};
      `OFF_WAVE_HDR: readMux = {15'h0, hdrMode[slotSel], hdrCycles[slotSel]};
      `OFF_WAVE_PROT: readMux = {hdrNeg[slotSel], hdrPos[slotSel]};
      `OFF_WAVE_NAME: readMux = hdrName[slotSel];
      `OFF_SEG_FREQ: readMux = {12'h0, stFreq};
      `OFF_SEG_SHAPE: readMux = {10'h0, stShape};
      `OFF_SEG_LEVEL: readMux = stLevel;
      `OFF_STATIC_SET: readMux = {15'h0, staticSet.currentMode, staticSet.level};
      `OFF_STATIC_PROT: readMux = {staticSet.protNeg, staticSet.protPos};
      `OFF_STATUS: readMux = statusWord; // [R18]
      `OFF_ERRORS: readMux = {28'h0, errors};
      `OFF_SETPOINT: readMux = {15'h0, outSet.currentMode, outSet.level};
      default: readMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      rdata <= 32'h0;
      errors <= 4'h0;
      ovrTimer <= 32'h0;
      overrunInd <= 1'b0;
      running <= 1'b0;
      outSet <= '0;
    end
    else if (ce)
    begin
      rdata <= rdEn ? readMux : 32'h0;
      // Set wins over a same-cycle write-one-to-clear
      errors <= (errors & ~((wrEn && addr == `OFF_ERRORS) ? wdata[3:0] : 4'h0)) | errSet;
      ovrTimer <= errSet[`ERR_OVERRUN] ? OVR_HOLD : (ovrTimer != 32'h0 ? ovrTimer - 32'h1 : 32'h0);
      overrunInd <= errSet[`ERR_OVERRUN] || ovrTimer > 32'h1; // [R9]
      running <= state != wave_seq_pkg::ST_IDLE || startOk;
      if (state == wave_seq_pkg::ST_PLAY)
        outSet <= '{currentMode: hdrMode[runSlot], level: genLevel,
          protPos: hdrPos[runSlot], protNeg: hdrNeg[runSlot]};
      else if (state == wave_seq_pkg::ST_IDLE)
        outSet <= staticSet; // [R17]
    end

endmodule // wave_seq

//--- bench/wave_seq_asserts.sv
// Port checker for wave_seq: bus echo, static hold, playback, overrun.
// Assumes ce is held high and binds onto every wave_seq instance.
`timescale 1ns/1ps

module wave_seq_asserts #(
  parameter int unsigned OVR_HOLD = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdata,
  input wire wave_seq_pkg::setpoint_t outSet,
  input wire logic running,
  input wire logic overrunInd
);
  // --------
  // Helpers
  // --------
  logic [15:0] lastStatic;
  int unsigned hiCnt;
  wire cmdWr = wrEn && addr == 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lastStatic <= 16'h0;
      hiCnt <= 0;
    end
    else
    begin
      lastStatic <= (wrEn && addr == 8'h08) ? wdata[15:0] : lastStatic;
      hiCnt <= overrunInd ? hiCnt + 1 : 0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // --------
  // Properties
  // --------
  run_start_a: assert property ($rose(running) |-> $past(cmdWr && wdata[0]))
    else $error("playback started without run command");
  // Running is registered from the state, so it drops one edge after the state does
  stop_idle_a: assert property (cmdWr && wdata[1] |-> ##2 !running)
    else $error("stop did not end playback");
  static_hold_a: assert property (!running && !$past(running) && !$past(running, 2)
    && !$past(wrEn) && !$past(wrEn, 2) && !$past(wrEn, 3) |-> $stable(outSet))
    else $error("idle output moved");
  // Two cycles covers write plus output register
  static_apply_a: assert property (!running && wrEn && addr == 8'h08
    |-> ##2 outSet.level == lastStatic)
    else $error("static level not applied");
  overrun_cause_a: assert property ($rose(overrunInd)
    |-> $past(cmdWr && wdata[2]) || $past(cmdWr && wdata[2], 2))
    else $error("overrun without segment add");
  overrun_len_a: assert property ($fell(overrunInd)
    |-> hiCnt >= OVR_HOLD - 1 && hiCnt <= OVR_HOLD + 1)
    else $error("overrun indication length wrong");
  overrun_end_a: assert property ($rose(overrunInd) |-> ##[1:12] !overrunInd)
    else $error("overrun indication stuck");
  setpoint_echo_a: assert property (rdEn && addr == 8'h0c
    |=> rdata[15:0] == $past(outSet.level))
    else $error("setpoint readback differs from output");

  cover property ($rose(overrunInd));
  cover property ($rose(running));
  cover property ($fell(running));
endmodule // wave_seq_asserts

bind wave_seq wave_seq_asserts #(.OVR_HOLD(OVR_HOLD)) i_wave_seq_asserts (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .addr(addr),
  .wdata(wdata),
  .wrEn(wrEn),
  .rdEn(rdEn),
  .rdata(rdata),
  .outSet(outSet),
  .running(running),
  .overrunInd(overrunInd)
);

//--- bench/output_stage_model.sv
// Output stage stand-in: applies setpoints and counts level steps.
// Assumes setpoints arrive registered on clk_sys.
`timescale 1ns/1ps

module output_stage_model (
  input wire logic clk_sys,
  input wire wave_seq_pkg::setpoint_t outSet
);
  wave_seq_pkg::setpoint_t applied;
  int nSteps = 0;

  always @(posedge clk_sys)
  begin
    if (outSet.level !== applied.level)
    begin
      nSteps <= nSteps + 1;
    end
    applied <= outSet;
  end
endmodule // output_stage_model

//--- bench/wave_seq_tb_top.sv
// Testbench for wave_seq: register sequences with expected values.
// Assumes the checker binds itself and OVR_HOLD is shortened to 8.
`timescale 1ns/1ps
`include "wave_seq_map.svh"

module wave_seq_tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [31:0] rdata;
  wave_seq_pkg::setpoint_t outSet;
  logic running;
  logic overrunInd;
  logic [31:0] d;
  int n_fail = 0;
  int n_checks = 0;
  int s0;
  // Kind, mHz, stop angle, error bits, points, segments after each add
  logic [2:0] tK [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h2, 3'h0, 3'h3};
  logic [19:0] tF [8] = '{443001, 443001, 532001, 532000, 1, 443000, 1000000, 443000};
  logic [8:0] tA [8] = '{0, 0, 0, 0, 0, 0, 0, 180};
  logic [3:0] tE [8] = '{4, 4, 4, 0, 0, 0, 1, 0};
  int tP [8] = '{0, 0, 0, 20, 3860, 3884, 3884, 3896};
  int tN [8] = '{0, 0, 0, 1, 2, 3, 3, 4};

  always #4 clk_sys = ~clk_sys;

  wave_seq #(.OVR_HOLD(8)) i_wave_seq (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(1'b1),
    .addr(addr),
    .wdata(wdata),
    .wrEn(wrEn),
    .rdEn(rdEn),
    .rdata(rdata),
    .outSet(outSet),
    .running(running),
    .overrunInd(overrunInd)
  );

  output_stage_model i_output_stage_model (
    .clk_sys(clk_sys),
    .outSet(outSet)
  );

  // --------
  // Bus tasks
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
  begin
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wrEn <= 1'b1;
    @(posedge clk_sys);
    wrEn <= 1'b0;
  end
  endtask

  task automatic rd(input logic [7:0] a);
  begin
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1 d = rdata;
  end
  endtask

  // Bit 3 of k marks the segment as initial-only
  task automatic seg(input logic [3:0] k, input logic [19:0] f, input logic [8:0] stopA);
  begin
    wr(`OFF_SEG_FREQ, {12'h0, f});
    wr(`OFF_SEG_SHAPE, {10'h0, stopA, 9'h0, k});
    wr(`OFF_SEG_LEVEL, 32'h0000_4000);
    wr(`OFF_COMMAND, 32'h4);
  end
  endtask

  task automatic errs(input logic [31:0] e);
  begin
    rd(`OFF_ERRORS);
    chk(d, e);
    wr(`OFF_ERRORS, 32'hf);
  end
  endtask

  task automatic stat(input int n, input int p);
  begin
    rd(`OFF_STATUS);
    chk(d & 32'h01ff_f0f0, (p << 12) | (n << 4));
  end
  endtask

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  end
  endtask

  // --------
  // Sequences
  // --------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`OFF_STATUS);
    chk(d, 32'h4);
    wr(`OFF_STATIC_SET, 32'h1234);
    rd(`OFF_SETPOINT);
    chk(d, 32'h1234);
    wr(`OFF_SELECT, 32'h10);
    wr(`OFF_COMMAND, 32'h10);
    wr(`OFF_STATIC_SET, 32'h0777);
    wr(`OFF_COMMAND, 32'h20);
    rd(`OFF_SETPOINT);
    chk(d, 32'h1234);
    $display("test static_recall done");
    wr(`OFF_SELECT, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      seg(tK[i], tF[i], tA[i]);
      #1 chk({31'h0, overrunInd}, {31'h0, tE[i][0]});
      errs({28'h0, tE[i]});
      stat(tN[i], tP[i]);
    end
    $display("test point_budget done");
    wr(`OFF_SELECT, 32'h2);
    repeat (10) seg(3'h1, 20'd1000000, 9'h0);
    stat(10, 100);
    seg(3'h1, 20'd1000000, 9'h0);
    errs(32'h2);
    stat(10, 100);
    wr(`OFF_COMMAND, 32'h8);
    rd(`OFF_STATUS);
    chk(d, 32'h4);
    $display("test count_erase done");
    wr(`OFF_SELECT, 32'h3);
    wr(`OFF_COMMAND, 32'h1);
    errs(32'h8);
    #1 chk({31'h0, running}, 32'h0);
    seg(3'h2, 20'd443000, 9'h0);
    wr(`OFF_WAVE_HDR, 32'h0);
    s0 = i_output_stage_model.nSteps;
    wr(`OFF_COMMAND, 32'h1);
    #1 chk({31'h0, running}, 32'h1);
    // About 11757 cycles per point at 24 points and 443 Hz
    repeat (26000) @(posedge clk_sys);
    #1 chk({31'h0, running}, 32'h1);
    s0 = i_output_stage_model.nSteps - s0;
    chk({31'h0, s0 >= 2 && s0 <= 4}, 32'h1);
    wr(`OFF_COMMAND, 32'h2);
    rd(`OFF_SETPOINT);
    chk(d, 32'h1234);
    $display("test playback done");
    // Two one-point level segments, both initial-only, two passes: about 6260 cycles
    wr(`OFF_SELECT, 32'h4);
    repeat (2) seg(4'h8, 20'd1000000, 9'd1);
    wr(`OFF_WAVE_HDR, 32'h2);
    wr(`OFF_COMMAND, 32'h1);
    repeat (5000) @(posedge clk_sys);
    #1 chk({31'h0, running}, 32'h1);
    repeat (2000) @(posedge clk_sys);
    #1 chk({31'h0, running}, 32'h0);
    $display("test passes done");
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
endmodule // wave_seq_tb_top
